// file: src/sphm_cfg.svh
`ifndef SPHM_CFG_SVH
`define SPHM_CFG_SVH

// Register indexes; the byte address is four times the index
`define SPHM_IDX_BUF 12'h18c
`define SPHM_IDX_ADDR 12'h18d
`define SPHM_IDX_MASK 12'h18e
`define SPHM_IDX_STAT 12'h18f
`define SPHM_IDX_CON1 12'h190
`define SPHM_IDX_CON2 12'h191
`define SPHM_IDX_CON3 12'h192
`define SPHM_IDX_IRQ_STAT 12'h193
`define SPHM_IDX_IRQ_MASK 12'h194

// Reset values
`define SPHM_RST_BYTE 8'h00
`define SPHM_RST_MASK 8'hff
`define SPHM_RST_MODE 4'h0
`define SPHM_RST_RELEASE 1'b1

// Mode field encodings
`define SPHM_MODE_SPI_SEL 4'h4
`define SPHM_MODE_SPI_NOSEL 4'h5
`define SPHM_MODE_I2C_A 4'h6
`define SPHM_MODE_I2C_B 4'h7
`define SPHM_MODE_I2C_C 4'he
`define SPHM_MODE_I2C_D 4'hf

// Control one fields
`define SPHM_C1_COLLIDE 7
`define SPHM_C1_OVF 6
`define SPHM_C1_EN 5
`define SPHM_C1_RELEASE 4

// Control three fields
`define SPHM_C3_ACKTIME 7
`define SPHM_C3_STOP_IE 6
`define SPHM_C3_START_IE 5
`define SPHM_C3_OVERWRITE 4
`define SPHM_C3_ADDR_HOLD 1
`define SPHM_C3_DATA_HOLD 0

// Interrupt status and mask fields
`define SPHM_IRQ_W 6
`define SPHM_IRQ_BYTE 0
`define SPHM_IRQ_START 1
`define SPHM_IRQ_STOP 2
`define SPHM_IRQ_OVF 3
`define SPHM_IRQ_COLLIDE 4
`define SPHM_IRQ_HOLD 5

`define SPHM_BITS_PER_BYTE 4'd8
`define SPHM_LAST_SPI_BIT 4'd7

`endif

// file: src/sphm_pkg.sv
package sphm_pkg;

  typedef enum logic [3:0] {
    sphm_st_idle = 4'b0001,
    sphm_st_addr = 4'b0010,
    sphm_st_data = 4'b0100,
    sphm_st_skip = 4'b1000
  } sphm_state_t;

  typedef struct packed {
    logic clk_rise;
    logic clk_fall;
    logic level;
    logic start;
    logic stop;
  } sphm_link_ev_t;

endpackage : sphm_pkg

// file: src/sphm_link.sv
module sphm_link (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lclk_pin,
  input wire logic ldata_pin,
  output sphm_pkg::sphm_link_ev_t ev
);

  logic clk_s1_ff;
  logic clk_s2_ff;
  logic clk_old_ff;
  logic dat_s1_ff;
  logic dat_s2_ff;
  logic dat_old_ff;

  // Two stages per pin, then one more for edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_ff <= 1'b1;
      clk_s2_ff <= 1'b1;
      clk_old_ff <= 1'b1;
      dat_s1_ff <= 1'b1;
      dat_s2_ff <= 1'b1;
      dat_old_ff <= 1'b1;
    end else begin
      clk_s1_ff <= lclk_pin;
      clk_s2_ff <= clk_s1_ff;
      clk_old_ff <= clk_s2_ff;
      dat_s1_ff <= ldata_pin;
      dat_s2_ff <= dat_s1_ff;
      dat_old_ff <= dat_s2_ff;
    end
  end

  // Data moving while the clock stays high marks start or stop
  assign ev = '{clk_rise: clk_s2_ff & ~clk_old_ff,
                clk_fall: ~clk_s2_ff & clk_old_ff,
                level: dat_s2_ff,
                start: clk_s2_ff & clk_old_ff & dat_old_ff & ~dat_s2_ff,
                stop: clk_s2_ff & clk_old_ff & ~dat_old_ff & dat_s2_ff};

endmodule : sphm_link

// file: src/sphm_top.sv
// Function
// - Address hold on: clear clock release after eighth falling edge of address byte.
// - Data hold on: clear clock release after eighth falling edge of received data byte.
// - Hold enable off: clock release untouched for that byte type.
// - Modes 1111 and 0111 report start and stop regardless of enables.
// - SPI overwrite on: byte into full buffer sets overflow, newest byte stored.
// - Control one: collision 7, overflow 6, enable 5, release 4, mode 3:0.
// - SPI overwrite off: byte into full buffer sets overflow, buffer unchanged.
// - Other I2C modes (0110, 1110): stop enable raises interrupt on a detected stop.
//
// Design decision made here: the APB interface to the registers.
`include "sphm_cfg.svh"

module sphm_top #(
  parameter int AW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sck_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic irq
);

  function automatic logic reg_hit(input logic [AW-1:0] a, input logic [11:0] idx);
    return (a[13:2] == idx) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  logic wr_acc;
  logic rd_acc;
  logic rd_setup;
  logic w_buf, w_addr, w_mask, w_stat, w_con1, w_con2, w_con3, w_imask;
  logic r_buf, r_irq, hit_any;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign w_buf = wr_acc & reg_hit(paddr, `SPHM_IDX_BUF);
  assign w_addr = wr_acc & reg_hit(paddr, `SPHM_IDX_ADDR);
  assign w_mask = wr_acc & reg_hit(paddr, `SPHM_IDX_MASK);
  assign w_stat = wr_acc & reg_hit(paddr, `SPHM_IDX_STAT);
  assign w_con1 = wr_acc & reg_hit(paddr, `SPHM_IDX_CON1);
  assign w_con2 = wr_acc & reg_hit(paddr, `SPHM_IDX_CON2);
  assign w_con3 = wr_acc & reg_hit(paddr, `SPHM_IDX_CON3);
  assign w_imask = wr_acc & reg_hit(paddr, `SPHM_IDX_IRQ_MASK);
  assign r_buf = rd_acc & reg_hit(paddr, `SPHM_IDX_BUF);
  assign r_irq = rd_acc & reg_hit(paddr, `SPHM_IDX_IRQ_STAT);
  assign hit_any = reg_hit(paddr, `SPHM_IDX_BUF) | reg_hit(paddr, `SPHM_IDX_ADDR)
                 | reg_hit(paddr, `SPHM_IDX_MASK) | reg_hit(paddr, `SPHM_IDX_STAT)
                 | reg_hit(paddr, `SPHM_IDX_CON1) | reg_hit(paddr, `SPHM_IDX_CON2)
                 | reg_hit(paddr, `SPHM_IDX_CON3) | reg_hit(paddr, `SPHM_IDX_IRQ_STAT)
                 | reg_hit(paddr, `SPHM_IDX_IRQ_MASK);

  logic collide_ff, ovf_ff, en_ff, release_ff;
  logic [3:0] mode_ff;
  logic [7:0] con2_ff;
  logic acktime_ff;
  logic [6:0] con3_ff;
  logic [1:0] stat_cfg_ff;
  logic dna_ff, stop_seen_ff, start_seen_ff, rw_ff, full_ff;
  logic [7:0] buf_ff, addr_ff, mask_ff, rx_ff, tx_ff, prdata_ff;
  logic [`SPHM_IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_set;
  logic [3:0] cnt_ff;
  logic ack_ff, ack_drive_ff;
  sphm_pkg::sphm_state_t state_ff;

  logic is_spi, is_i2c, sp_auto, ovw, ahold, dhold;
  assign is_spi = en_ff & (mode_ff == `SPHM_MODE_SPI_SEL || mode_ff == `SPHM_MODE_SPI_NOSEL);
  assign is_i2c = en_ff & (mode_ff == `SPHM_MODE_I2C_A || mode_ff == `SPHM_MODE_I2C_B
                  || mode_ff == `SPHM_MODE_I2C_C || mode_ff == `SPHM_MODE_I2C_D);
  assign sp_auto = (mode_ff == `SPHM_MODE_I2C_D) || (mode_ff == `SPHM_MODE_I2C_B);
  assign ovw = con3_ff[`SPHM_C3_OVERWRITE];
  assign ahold = con3_ff[`SPHM_C3_ADDR_HOLD];
  assign dhold = con3_ff[`SPHM_C3_DATA_HOLD];

  // Pins are muxed before the synchroniser; mode changes are quasi-static
  logic lclk_mux, ldata_mux;
  sphm_pkg::sphm_link_ev_t ev;
  assign lclk_mux = is_spi ? sck_in : scl_in;
  assign ldata_mux = is_spi ? sdi_in : sda_in;

  sphm_link u_link (
    .pclk(pclk),
    .presetn(presetn),
    .lclk_pin(lclk_mux),
    .ldata_pin(ldata_mux),
    .ev(ev)
  );

  logic busy, byte_end, addr_match, spi_end, addr_take, data_take, rx_take;
  logic buf_upd, hold_hit, xfer_active, collide, tx_drive, start_ev, stop_ev;
  logic [7:0] rx_byte;

  assign busy = (state_ff == sphm_pkg::sphm_st_addr) || (state_ff == sphm_pkg::sphm_st_data);
  assign byte_end = is_i2c & busy & ev.clk_fall & (cnt_ff == `SPHM_BITS_PER_BYTE) & ~ack_ff;
  assign addr_match = ((rx_ff[7:1] ^ addr_ff[7:1]) & mask_ff[7:1]) == 7'h00;
  assign spi_end = is_spi & ev.clk_rise & (cnt_ff == `SPHM_LAST_SPI_BIT);
  assign addr_take = byte_end & (state_ff == sphm_pkg::sphm_st_addr) & addr_match;
  assign data_take = byte_end & (state_ff == sphm_pkg::sphm_st_data) & ~rw_ff;
  assign rx_take = spi_end | addr_take | data_take;
  assign rx_byte = is_spi ? {rx_ff[6:0], ev.level} : rx_ff;
  // Overwrite lets a daisy chain keep only the last byte
  assign buf_upd = rx_take & (is_spi ? (~full_ff | ovw) : (ovw | (~ovf_ff & ~full_ff)));
  assign hold_hit = (addr_take & ahold) | (data_take & dhold);
  assign xfer_active = is_spi ? (cnt_ff != 4'd0) : (busy & (cnt_ff != 4'd0) & ~ack_ff);
  assign collide = w_buf & xfer_active;
  assign tx_drive = is_i2c & (state_ff == sphm_pkg::sphm_st_data) & rw_ff & ~ack_ff;
  assign start_ev = is_i2c & ev.start & (sp_auto | con3_ff[`SPHM_C3_START_IE]);
  assign stop_ev = is_i2c & ev.stop & (sp_auto | con3_ff[`SPHM_C3_STOP_IE]);

  // Client protocol state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= sphm_pkg::sphm_st_idle;
    end else if (!is_i2c || ev.stop) begin
      state_ff <= sphm_pkg::sphm_st_idle;
    end else if (ev.start) begin
      state_ff <= sphm_pkg::sphm_st_addr;
    end else if (byte_end && state_ff == sphm_pkg::sphm_st_addr) begin
      state_ff <= addr_match ? sphm_pkg::sphm_st_data : sphm_pkg::sphm_st_skip;
    end else if (ev.clk_rise && ack_ff && rw_ff && ev.level
                 && state_ff == sphm_pkg::sphm_st_data) begin
      // Host refused the last byte it read: stay off the bus until restart
      state_ff <= sphm_pkg::sphm_st_skip;
    end
  end

  // Bit counter, receive shifter and acknowledge slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'd0;
      ack_ff <= 1'b0;
      rx_ff <= `SPHM_RST_BYTE;
    end else if ((!is_i2c && !is_spi) || (is_i2c && (ev.start || !busy))) begin
      cnt_ff <= 4'd0;
      ack_ff <= 1'b0;
    end else if (is_spi) begin
      if (ev.clk_rise) begin
        rx_ff <= {rx_ff[6:0], ev.level};
        cnt_ff <= spi_end ? 4'd0 : cnt_ff + 4'd1;
      end
    end else if (ev.clk_rise && !ack_ff && cnt_ff != `SPHM_BITS_PER_BYTE) begin
      rx_ff <= {rx_ff[6:0], ev.level};
      cnt_ff <= cnt_ff + 4'd1;
    end else if (ev.clk_fall && ack_ff) begin
      ack_ff <= 1'b0;
      cnt_ff <= 4'd0;
    end else if (byte_end) begin
      ack_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_drive_ff <= 1'b0;
    end else if (byte_end) begin
      ack_drive_ff <= addr_take | (data_take & buf_upd);
    end else if (!ack_ff) begin
      ack_drive_ff <= 1'b0;
    end
  end

  // Transmit shifter feeds SDO and client reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ff <= `SPHM_RST_BYTE;
    end else if (w_buf && !collide) begin
      tx_ff <= pwdata[7:0];
    end else if (ev.clk_fall && (is_spi || (tx_drive && cnt_ff != 4'd0
                 && cnt_ff != `SPHM_BITS_PER_BYTE))) begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // Shift buffer, full flag and overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ff <= `SPHM_RST_BYTE;
    end else if (buf_upd) begin
      buf_ff <= rx_byte;
    end else if (w_buf && !collide) begin
      buf_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_ff <= 1'b0;
    end else if (buf_upd) begin
      full_ff <= 1'b1;
    end else if (r_buf) begin
      full_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ff <= 1'b0;
    end else if (rx_take && full_ff) begin
      ovf_ff <= 1'b1;
    end else if (w_con1 && !pwdata[`SPHM_C1_OVF]) begin
      ovf_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collide_ff <= 1'b0;
    end else if (collide) begin
      collide_ff <= 1'b1;
    end else if (w_con1 && !pwdata[`SPHM_C1_COLLIDE]) begin
      collide_ff <= 1'b0;
    end
  end

  // Hardware hold beats a same-cycle software release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_ff <= `SPHM_RST_RELEASE;
    end else if (is_i2c && hold_hit) begin
      release_ff <= 1'b0;
    end else if (w_con1) begin
      release_ff <= pwdata[`SPHM_C1_RELEASE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 1'b0;
      mode_ff <= `SPHM_RST_MODE;
    end else if (w_con1) begin
      en_ff <= pwdata[`SPHM_C1_EN];
      mode_ff <= pwdata[3:0];
    end
  end

  // Plain configuration storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff <= `SPHM_RST_BYTE;
      mask_ff <= `SPHM_RST_MASK;
      con2_ff <= `SPHM_RST_BYTE;
      con3_ff <= 7'h00;
      stat_cfg_ff <= 2'b00;
      irq_mask_ff <= '0;
    end else begin
      if (w_addr) addr_ff <= pwdata[7:0];
      if (w_mask) mask_ff <= pwdata[7:0];
      if (w_con2) con2_ff <= pwdata[7:0];
      if (w_con3) con3_ff <= pwdata[6:0];
      if (w_stat) stat_cfg_ff <= pwdata[7:6];
      if (w_imask) irq_mask_ff <= pwdata[`SPHM_IRQ_W-1:0];
    end
  end

  // Bus status seen by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acktime_ff <= 1'b0;
      dna_ff <= 1'b0;
      rw_ff <= 1'b0;
      start_seen_ff <= 1'b0;
      stop_seen_ff <= 1'b0;
    end else begin
      if (byte_end && (ahold || dhold)) begin
        acktime_ff <= 1'b1;
      end else if (ev.clk_rise && ack_ff) begin
        acktime_ff <= 1'b0;
      end
      if (addr_take) begin
        dna_ff <= 1'b0;
        rw_ff <= rx_ff[0];
      end else if (data_take) begin
        dna_ff <= 1'b1;
      end
      if (is_i2c && ev.start) begin
        start_seen_ff <= 1'b1;
        stop_seen_ff <= 1'b0;
      end else if (is_i2c && ev.stop) begin
        start_seen_ff <= 1'b0;
        stop_seen_ff <= 1'b1;
        rw_ff <= 1'b0;
      end
    end
  end

  // Sticky events; a new event in the read cycle survives the clear
  assign irq_set = {hold_hit & is_i2c, collide, rx_take & full_ff, stop_ev, start_ev, rx_take};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (r_irq ? '0 : irq_stat_ff) | irq_set;
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(paddr, `SPHM_IDX_BUF)) rd_byte = buf_ff;
    if (reg_hit(paddr, `SPHM_IDX_ADDR)) rd_byte = addr_ff;
    if (reg_hit(paddr, `SPHM_IDX_MASK)) rd_byte = mask_ff;
    if (reg_hit(paddr, `SPHM_IDX_STAT)) begin
      rd_byte = {stat_cfg_ff, dna_ff, stop_seen_ff, start_seen_ff, rw_ff, 1'b0, full_ff};
    end
    if (reg_hit(paddr, `SPHM_IDX_CON1)) begin
      rd_byte = {collide_ff, ovf_ff, en_ff, release_ff, mode_ff};
    end
    if (reg_hit(paddr, `SPHM_IDX_CON2)) rd_byte = con2_ff;
    if (reg_hit(paddr, `SPHM_IDX_CON3)) rd_byte = {acktime_ff, con3_ff};
    if (reg_hit(paddr, `SPHM_IDX_IRQ_STAT)) rd_byte = {2'b00, irq_stat_ff};
    if (reg_hit(paddr, `SPHM_IDX_IRQ_MASK)) rd_byte = {2'b00, irq_mask_ff};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 8'h00;
    end else if (rd_setup) begin
      prdata_ff <= rd_byte;
    end
  end

  assign prdata = {24'h000000, prdata_ff};
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign irq = |(irq_stat_ff & irq_mask_ff);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = is_i2c & busy & ~release_ff;
  assign sda_oe = (ack_ff & ack_drive_ff) | (tx_drive & ~tx_ff[7]);
  assign sdo_out = tx_ff[7];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_hold_clear: assert property (
    addr_take && ahold && is_i2c |=> !release_ff && (scl_oe || !is_i2c))
    else $error("address hold did not stretch the clock");
  a_data_hold_clear: assert property (
    data_take && dhold && is_i2c |=> !release_ff ##1 !release_ff || $past(w_con1))
    else $error("data hold did not clear clock release");
  a_no_hold_keep: assert property (
    byte_end && release_ff && !ahold && !dhold && !w_con1 |=> release_ff)
    else $error("clock release cleared with holds off");
  a_release_write: assert property (
    w_con1 && pwdata[`SPHM_C1_RELEASE] && !(is_i2c && hold_hit) |=> release_ff)
    else $error("software release not taken");
  a_auto_start_irq: assert property (
    is_i2c && ev.start && sp_auto && !con3_ff[`SPHM_C3_START_IE]
    |=> irq_stat_ff[`SPHM_IRQ_START])
    else $error("automatic start report lost");
  a_ovw_store: assert property (
    is_spi && rx_take && full_ff && ovw |=> buf_ff == $past(rx_byte) && ovf_ff)
    else $error("overwrite did not keep newest byte");
  a_ovf_keep: assert property (
    is_spi && rx_take && full_ff && !ovw
    |=> $stable(buf_ff) && ovf_ff && (full_ff || $past(r_buf)))
    else $error("buffer changed on overflow");
  a_stop_irq_set: assert property (
    is_i2c && ev.stop && !sp_auto && con3_ff[`SPHM_C3_STOP_IE] && irq_mask_ff[`SPHM_IRQ_STOP]
    |=> irq ##1 irq || $past(r_irq))
    else $error("stop interrupt missing");
  a_ctrl_layout: assert property (
    rd_setup && reg_hit(paddr, `SPHM_IDX_CON1)
    |=> prdata[7:0] == {$past(collide_ff), $past(ovf_ff), $past(en_ff),
                        $past(release_ff), $past(mode_ff)})
    else $error("control one layout wrong");
  a_scl_stretch: assert property (
    scl_oe && w_con1 && pwdata[`SPHM_C1_RELEASE] && !hold_hit |=> !scl_oe)
    else $error("clock still held after software release");

  c_addr_hold: cover property (addr_take && ahold ##[1:400] w_con1 && pwdata[`SPHM_C1_RELEASE]);
  c_data_hold: cover property (data_take && dhold);
  c_spi_overwrite: cover property (is_spi && rx_take && full_ff && ovw);
  c_stop_irq: cover property (stop_ev && !sp_auto);

endmodule : sphm_top

// file: sim/sphm_host_model.sv
module sphm_host_model (
  input wire logic pclk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic sdo,
  output logic scl_w,
  output logic sda_w,
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;

  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  logic [7:0] miso_got = 8'h00;

  // Both lines have pull-ups, so a released line reads high
  assign scl_w = !(scl_low || scl_oe);
  assign sda_w = !(sda_low || sda_oe);

  initial begin
    sck = 1'b0;
    sdi = 1'b1;
  end

  // Half of the 80 ns link period
  task automatic half();
    repeat (5) @(posedge pclk);
  endtask : half

  task automatic start_c();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    half();
  endtask : start_c

  task automatic stop_c();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b0;
    half();
    sda_low <= 1'b0;
    half();
  endtask : stop_c

  // SDA only moves while SCL is low, so no false start or stop is seen
  task automatic bits8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      half();
      scl_low <= 1'b0;
      half();
      scl_low <= 1'b1;
      half();
    end
    sda_low <= 1'b0;
  endtask : bits8

  // Ninth clock; waits while the client stretches SCL, but not forever
  task automatic ack9(output logic acked);
    int k;
    half();
    scl_low <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!scl_w && k < 400);
    acked = !sda_w && scl_w;
    half();
    scl_low <= 1'b1;
    half();
  endtask : ack9

  task automatic spi_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdi <= b[i];
      half();
      miso_got = {miso_got[6:0], sdo};
      sck <= 1'b1;
      half();
      sck <= 1'b0;
    end
    // Data line is not held after the frame
    sdi <= ~b[0];
    half();
  endtask : spi_byte
endmodule : sphm_host_model

// file: sim/sphm_top_bench.sv
`include "sphm_cfg.svh"

module sphm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready, pslverr, irq, err, acked;
  logic [31:0] prdata, rd;
  logic scl_w, sda_w, scl_oe, sda_oe, sck, sdi, scl_o, sda_o, sdo;
  logic [7:0] ss_c1 [4] = '{8'h3e, 8'h36, 8'h37, 8'h3f};
  logic [7:0] ss_c3 [4] = '{8'h00, 8'h60, 8'h00, 8'h00};
  logic [7:0] ss_exp [4] = '{8'h00, 8'h06, 8'h06, 8'h06};
  int fails = 0;
  int samples_checked = 0;

  always #4 pclk = ~pclk;

  sphm_top #(.AW(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe(sda_oe), .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo), .irq(irq)
  );

  sphm_host_model host (
    .pclk(pclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_w(scl_w), .sda_w(sda_w),
    .sck(sck), .sdi(sdi), .sdo(sdo)
  );

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask : tdone

  // One APB transfer; an idle edge follows so the next setup never collides
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      fails++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input string n, input logic [11:0] idx, input logic [7:0] exp,
                       input logic [7:0] m);
    apb(1'b0, idx, 8'h00);
    chk(n, {24'h000000, exp}, rd & {24'h000000, m});
  endtask : rdchk

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    finish_test();
  end

  initial begin
    do_reset();
    rdchk("con1_reset", `SPHM_IDX_CON1, 8'h10, 8'hff);
    rdchk("mask_reset", `SPHM_IDX_MASK, 8'hff, 8'hff);
    rdchk("con3_reset", `SPHM_IDX_CON3, 8'h00, 8'hff);
    apb(1'b1, 12'h195, 8'h5a);
    chk("unmapped_err", 32'h1, {31'h0, err});
    rdchk("unmapped_rd", 12'h195, 8'h00, 8'hff);
    tdone("reset_map");

    apb(1'b1, `SPHM_IDX_CON1, 8'h34);
    // Loaded after the mode switch so the mux edge cannot shift it
    apb(1'b1, `SPHM_IDX_BUF, 8'hc3);
    host.spi_byte(8'ha5);
    chk("spi_tx", 32'hc3, {24'h000000, host.miso_got});
    host.spi_byte(8'h3c);
    rdchk("ovf_bit6", `SPHM_IDX_CON1, 8'h74, 8'hff);
    rdchk("buf_kept", `SPHM_IDX_BUF, 8'ha5, 8'hff);
    tdone("spi_no_overwrite");

    // Fresh reset so the overflow flag and status left above cannot colour this case
    do_reset();
    apb(1'b1, `SPHM_IDX_IRQ_MASK, 8'h00);
    apb(1'b1, `SPHM_IDX_CON3, 8'h10);
    apb(1'b1, `SPHM_IDX_CON1, 8'h35);
    host.spi_byte(8'ha5);
    host.spi_byte(8'h3c);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("ovf_set", `SPHM_IDX_CON1, 8'h75, 8'hff);
    rdchk("buf_newest", `SPHM_IDX_BUF, 8'h3c, 8'hff);
    apb(1'b1, `SPHM_IDX_IRQ_MASK, 8'h08);
    chk("irq_raised", 32'h1, {31'h0, irq});
    rdchk("irq_status", `SPHM_IDX_IRQ_STAT, 8'h08, 8'h08);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    tdone("spi_overwrite_irq");

    apb(1'b1, `SPHM_IDX_ADDR, 8'h84);
    apb(1'b1, `SPHM_IDX_CON3, 8'h12);
    apb(1'b1, `SPHM_IDX_CON1, 8'h36);
    host.start_c();
    host.bits8(8'h84);
    chk("addr_stretch", 32'h1, {31'h0, scl_oe});
    chk("pin_levels", 32'h0, {30'h0, scl_o, sda_o});
    rdchk("addr_hold", `SPHM_IDX_CON1, 8'h26, 8'h3f);
    apb(1'b1, `SPHM_IDX_CON1, 8'h36);
    chk("stretch_end", 32'h0, {31'h0, scl_oe});
    host.ack9(acked);
    chk("addr_ack", 32'h1, {31'h0, acked});
    host.bits8(8'h99);
    rdchk("no_data_hold", `SPHM_IDX_CON1, 8'h36, 8'h3f);
    chk("no_stretch", 32'h0, {31'h0, scl_oe});
    host.ack9(acked);
    apb(1'b1, `SPHM_IDX_CON3, 8'h11);
    host.bits8(8'h77);
    rdchk("data_hold", `SPHM_IDX_CON1, 8'h26, 8'h3f);
    apb(1'b1, `SPHM_IDX_CON1, 8'h36);
    host.ack9(acked);
    chk("data_ack", 32'h1, {31'h0, acked});
    host.stop_c();
    tdone("i2c_hold");

    apb(1'b1, `SPHM_IDX_IRQ_MASK, 8'h04);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SPHM_IDX_CON1, ss_c1[i]);
      apb(1'b1, `SPHM_IDX_CON3, ss_c3[i]);
      apb(1'b0, `SPHM_IDX_IRQ_STAT, 8'h00);
      host.start_c();
      host.stop_c();
      chk("stop_irq_pin", {31'h0, ss_exp[i][2]}, {31'h0, irq});
      rdchk("start_stop_irq", `SPHM_IDX_IRQ_STAT, ss_exp[i], 8'h06);
    end
    tdone("start_stop");
    finish_test();
  end
endmodule : sphm_top_bench
